//--- rtl/cmpsr_regs.sv
// comparator select and status register bank with an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none

module cmpsr_regs #(
   parameter int unsigned NCMP = 3               // comparator count
) (
   input  wire logic                           i_clk,       // 125 MHz clock
   input  wire logic                           i_rst_b,     // async reset
   input  wire logic                           i_idle,      // system idle
   input  wire logic [NCMP-1:0]                i_cmp_event, // cell events
   input  wire logic [NCMP-1:0]                i_cmp_out,   // cell outputs
   output var  logic [NCMP-1:0]                o_noninv_sel,// 1: internal
   output var  logic [NCMP*cmpsr_pkg::INV_W-1:0] o_inv_sel, // inverting mux
   output var  logic                           o_irq,       // level irq
   input  wire logic [cmpsr_pkg::ADDR_W-1:0]   s_axi_awaddr,  // wr addr
   input  wire logic                           s_axi_awvalid, // wr addr vld
   output var  logic                           s_axi_awready, // wr addr rdy
   input  wire logic [cmpsr_pkg::DATA_W-1:0]   s_axi_wdata,   // wr data
   input  wire logic [3:0]                     s_axi_wstrb,   // byte lanes
   input  wire logic                           s_axi_wvalid,  // wr data vld
   output var  logic                           s_axi_wready,  // wr data rdy
   output var  logic [1:0]                     s_axi_bresp,   // wr resp
   output var  logic                           s_axi_bvalid,  // wr resp vld
   input  wire logic                           s_axi_bready,  // wr resp rdy
   input  wire logic [cmpsr_pkg::ADDR_W-1:0]   s_axi_araddr,  // rd addr
   input  wire logic                           s_axi_arvalid, // rd addr vld
   output var  logic                           s_axi_arready, // rd addr rdy
   output var  logic [cmpsr_pkg::DATA_W-1:0]   s_axi_rdata,   // rd data
   output var  logic [1:0]                     s_axi_rresp,   // rd resp
   output var  logic                           s_axi_rvalid,  // rd data vld
   input  wire logic                           s_axi_rready   // rd data rdy
);
   import cmpsr_pkg::*;

   // -----------------------------------------------------------------
   // elaboration check
   // -----------------------------------------------------------------
   if (NCMP != NUM_CMP) begin : g_bad_ncmp
      $error("cmpsr_regs: status layout serves exactly three comparators");
   end

   if (DATA_W != 32) begin : g_bad_data
      $error("cmpsr_regs: bus data must be one 32-bit word");
   end

   if (ADDR_W < 5) begin : g_bad_addr
      $error("cmpsr_regs: register map needs five address bits");
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      // synchronised cell inputs
      logic [NCMP-1:0]       evt_s1;
      logic [NCMP-1:0]       evt_s2;
      logic [NCMP-1:0]       evt_prev;
      logic [NCMP-1:0]       out_s1;
      logic [NCMP-1:0]       out_s2;
      // register fields
      logic [NCMP-1:0]       noninv;
      logic [NCMP*INV_W-1:0] inv;
      logic                  stop_idle;
      logic [NCMP-1:0]       irq_stat;
      logic [NCMP-1:0]       irq_en;
      logic                  irq;
      // bus channels
      logic                  aw_full;
      logic [ADDR_W-1:0]     aw_addr;
      logic                  w_full;
      logic [REG_W-1:0]      w_data;
      logic [1:0]            w_strb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [DATA_W-1:0]     rdata;
      logic [1:0]            rresp;
      logic                  aw_rdy;
      logic                  w_rdy;
      logic                  ar_rdy;
   } cmpsr_state_t;

   cmpsr_state_t state_q;
   cmpsr_state_t state_d;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // register select from a byte address
   function automatic cmpsr_sel_t decode(input logic [ADDR_W-1:0] addr);
      cmpsr_sel_t sel;
      sel = CMPSR_SEL_NONE;
      unique case (addr)
         OFS_CTRL1:    sel = CMPSR_SEL_CTRL1;
         OFS_CTRL2:    sel = CMPSR_SEL_CTRL2;
         OFS_CTRL3:    sel = CMPSR_SEL_CTRL3;
         OFS_STATUS:   sel = CMPSR_SEL_STATUS;
         OFS_INT_STAT: sel = CMPSR_SEL_INT_STAT;
         OFS_INT_CLR:  sel = CMPSR_SEL_INT_CLR;
         OFS_INT_EN:   sel = CMPSR_SEL_INT_EN;
         default:      sel = CMPSR_SEL_NONE;
      endcase
      return sel;
   endfunction

   // merge 16-bit write data into an old value under the two low strobes
   function automatic logic [REG_W-1:0] merge(
      input logic [REG_W-1:0] old_v,
      input logic [REG_W-1:0] new_v,
      input logic [1:0]       strb
   );
      logic [REG_W-1:0] res;
      res = old_v;
      if (strb[0]) begin
         res[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         res[15:8] = new_v[15:8];
      end
      return res;
   endfunction

   // control register image of comparator n
   function automatic logic [REG_W-1:0] ctrl_image(
      input cmpsr_state_t s,
      input int unsigned  n
   );
      logic [REG_W-1:0] img;
      img = '0;
      img[CTL_EVENT_BIT]  = s.evt_s2[n];
      img[CTL_OUTPUT_BIT] = s.out_s2[n];
      img[CTL_NONINV_BIT] = s.noninv[n];
      img[CTL_INV_LSB +: INV_W] = s.inv[n*INV_W +: INV_W];
      return img;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      cmpsr_sel_t       wsel;
      cmpsr_sel_t       rsel;
      logic [REG_W-1:0] img;
      logic [NCMP-1:0]  evt_rise;
      logic [NCMP-1:0]  clr;
      logic             do_wr;
      int unsigned      idx;
      state_d  = state_q;
      wsel     = decode(state_q.aw_addr);
      rsel     = decode(s_axi_araddr);
      img      = '0;
      clr      = '0;
      idx      = 0;
      evt_rise = state_q.evt_s2 & ~state_q.evt_prev;
      // a write waits until its earlier response has been taken
      do_wr    = state_q.aw_full && state_q.w_full && !state_q.bvalid;

      // ------------------------------------------------------------
      // input synchronisers
      // ------------------------------------------------------------
      // cell signals come from the analog side: two flops first
      state_d.evt_s1   = i_cmp_event;
      state_d.evt_s2   = state_q.evt_s1;
      state_d.evt_prev = state_q.evt_s2;
      state_d.out_s1   = i_cmp_out;
      state_d.out_s2   = state_q.out_s1;

      // ------------------------------------------------------------
      // write address and data
      // ------------------------------------------------------------
      // write channels taken independently
      if (s_axi_awvalid && !state_q.aw_full) begin
         state_d.aw_full = 1'b1;
         state_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_q.w_full) begin
         state_d.w_full = 1'b1;
         state_d.w_data = s_axi_wdata[REG_W-1:0];
         state_d.w_strb = s_axi_wstrb[1:0];
      end
      if (state_q.bvalid && s_axi_bready) begin
         state_d.bvalid = 1'b0;
      end

      // ------------------------------------------------------------
      // register write
      // ------------------------------------------------------------
      if (do_wr) begin
         state_d.aw_full = 1'b0;
         state_d.w_full  = 1'b0;
         state_d.bvalid  = 1'b1;
         state_d.bresp   = RESP_OKAY;
         unique case (wsel)
            CMPSR_SEL_CTRL1, CMPSR_SEL_CTRL2, CMPSR_SEL_CTRL3: begin
               idx = (wsel == CMPSR_SEL_CTRL1) ? 0 :
                     (wsel == CMPSR_SEL_CTRL2) ? 1 : 2;
               // mirrors and reserved bits fall out of the merge
               img = merge(ctrl_image(state_q, idx), state_q.w_data,
                           state_q.w_strb);
               state_d.noninv[idx] = img[CTL_NONINV_BIT];
               state_d.inv[idx*INV_W +: INV_W] =
                  img[CTL_INV_LSB +: INV_W];
            end
            CMPSR_SEL_STATUS: begin
               // only stop-in-idle is stored; mirrors ignore writes
               if (state_q.w_strb[1]) begin
                  state_d.stop_idle = state_q.w_data[STAT_IDLE_BIT];
               end
            end
            CMPSR_SEL_INT_CLR: begin
               if (state_q.w_strb[0]) begin
                  clr = state_q.w_data[NCMP-1:0];
               end
            end
            CMPSR_SEL_INT_EN: begin
               if (state_q.w_strb[0]) begin
                  state_d.irq_en = state_q.w_data[NCMP-1:0];
               end
            end
            CMPSR_SEL_INT_STAT: begin
               state_d.bresp = RESP_OKAY;
            end
            CMPSR_SEL_NONE: begin
               state_d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // ------------------------------------------------------------
      // interrupt
      // ------------------------------------------------------------
      // idle only masks the request; sticky status keeps collecting
      // sticky events: a new event wins over a clear in the same cycle
      state_d.irq_stat = (state_q.irq_stat & ~clr) | evt_rise;

      // interrupt from enabled status bits, gated by idle with stop-in-idle set
      state_d.irq = |(state_q.irq_stat & state_q.irq_en) &&
                    !(state_q.stop_idle && i_idle);

      // ------------------------------------------------------------
      // read channel
      // ------------------------------------------------------------
      // one read at a time: arready stays low while rvalid stands
      if (state_q.rvalid && s_axi_rready) begin
         state_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !state_q.rvalid) begin
         state_d.rvalid = 1'b1;
         state_d.rresp  = RESP_OKAY;
         state_d.rdata  = '0;
         unique case (rsel)
            CMPSR_SEL_CTRL1: begin
               state_d.rdata[REG_W-1:0] = ctrl_image(state_q, 0);
            end
            CMPSR_SEL_CTRL2: begin
               state_d.rdata[REG_W-1:0] = ctrl_image(state_q, 1);
            end
            CMPSR_SEL_CTRL3: begin
               state_d.rdata[REG_W-1:0] = ctrl_image(state_q, 2);
            end
            CMPSR_SEL_STATUS: begin
               // everything not set here reads zero
               state_d.rdata[STAT_IDLE_BIT] = state_q.stop_idle;
               state_d.rdata[STAT_EVENT_LSB +: NCMP] =
                  state_q.evt_s2;
               state_d.rdata[STAT_OUT_LSB +: NCMP] =
                  state_q.out_s2;
            end
            CMPSR_SEL_INT_STAT: begin
               state_d.rdata[NCMP-1:0] = state_q.irq_stat;
            end
            CMPSR_SEL_INT_EN: begin
               state_d.rdata[NCMP-1:0] = state_q.irq_en;
            end
            CMPSR_SEL_INT_CLR: begin
               state_d.rdata = '0;
            end
            CMPSR_SEL_NONE: begin
               state_d.rresp = RESP_SLVERR;
            end
         endcase
      end

      // ------------------------------------------------------------
      // ready flags
      // ------------------------------------------------------------
      // kept as flops so that every bus output leaves a register
      state_d.aw_rdy = !state_d.aw_full;
      state_d.w_rdy  = !state_d.w_full;
      state_d.ar_rdy = !state_d.rvalid;
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q           <= '0;
         state_q.noninv    <= {NCMP{RST_NONINV}};
         state_q.inv       <= {NCMP{RST_INV}};
         state_q.stop_idle <= RST_IDLE;
         state_q.irq_en    <= RST_IRQ;
         state_q.irq_stat  <= RST_IRQ;
         state_q.bresp     <= RESP_OKAY;
         state_q.rresp     <= RESP_OKAY;
         state_q.aw_rdy    <= RST_READY;
         state_q.w_rdy     <= RST_READY;
         state_q.ar_rdy    <= RST_READY;
      end else begin
         state_q <= state_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // all outputs straight from the state register
   assign o_noninv_sel  = state_q.noninv;
   assign o_inv_sel     = state_q.inv;
   assign o_irq         = state_q.irq;
   assign s_axi_awready = state_q.aw_rdy;
   assign s_axi_wready  = state_q.w_rdy;
   assign s_axi_bvalid  = state_q.bvalid;
   assign s_axi_bresp   = state_q.bresp;
   assign s_axi_arready = state_q.ar_rdy;
   assign s_axi_rvalid  = state_q.rvalid;
   assign s_axi_rdata   = state_q.rdata;
   assign s_axi_rresp   = state_q.rresp;

endmodule

`default_nettype wire

//--- rtl/cmpsr_pkg.sv
// package: register map, field layout and reset values of the comparator regs
package cmpsr_pkg;

   // -----------------------------------------------------------------
   // bus geometry
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned REG_W    = 16;
   localparam int unsigned NUM_CMP  = 3;

   // -----------------------------------------------------------------
   // byte offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL1    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL2    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CTRL3    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_INT_CLR  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_INT_EN   = 8'h18;

   // -----------------------------------------------------------------
   // comparator_control fields
   // -----------------------------------------------------------------
   localparam int unsigned CTL_EVENT_BIT  = 9;
   localparam int unsigned CTL_OUTPUT_BIT = 8;
   localparam int unsigned CTL_NONINV_BIT = 4;
   localparam int unsigned CTL_INV_LSB    = 0;
   localparam int unsigned INV_W          = 2;

   // inverting input channel codes
   localparam logic [1:0] INV_PIN_B     = 2'h0;
   localparam logic [1:0] INV_PIN_C     = 2'h1;
   localparam logic [1:0] INV_PIN_D     = 2'h2;
   localparam logic [1:0] INV_HALF_BGAP = 2'h3;

   // -----------------------------------------------------------------
   // comparator_module_status fields
   // -----------------------------------------------------------------
   localparam int unsigned STAT_IDLE_BIT  = 15;
   localparam int unsigned STAT_EVENT_LSB = 8;
   localparam int unsigned STAT_OUT_LSB   = 0;

   // -----------------------------------------------------------------
   // reset values and responses
   // -----------------------------------------------------------------
   localparam logic [1:0] RST_INV    = 2'h0;
   localparam logic       RST_NONINV = 1'b0;
   localparam logic       RST_IDLE   = 1'b0;
   localparam logic [2:0] RST_IRQ    = 3'h0;
   localparam logic       RST_READY  = 1'b1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CMPSR_SEL_CTRL1,
      CMPSR_SEL_CTRL2,
      CMPSR_SEL_CTRL3,
      CMPSR_SEL_STATUS,
      CMPSR_SEL_INT_STAT,
      CMPSR_SEL_INT_CLR,
      CMPSR_SEL_INT_EN,
      CMPSR_SEL_NONE
   } cmpsr_sel_t;

endpackage

//--- tb/cmpsr_regs_monitor.sv
// checker: bus timing, reserved bits, mirrors and idle gating
`timescale 1ns/100ps
`default_nettype none
module cmpsr_regs_monitor #(
   parameter int unsigned NCMP = 3 // comparator count
) (
   input wire logic              i_clk,         // clock
   input wire logic              i_rst_b,       // reset
   input wire logic              i_idle,        // idle
   input wire logic [NCMP-1:0]   i_cmp_event,   // events
   input wire logic [NCMP-1:0]   i_cmp_out,     // outputs
   input wire logic [NCMP-1:0]   o_noninv_sel,  // noninv mux
   input wire logic [NCMP*2-1:0] o_inv_sel,     // inv mux
   input wire logic              o_irq,         // irq
   input wire logic [7:0]        s_axi_awaddr,  // wr addr
   input wire logic              s_axi_awvalid, // wr addr vld
   input wire logic              s_axi_awready, // wr addr rdy
   input wire logic [31:0]       s_axi_wdata,   // wr data
   input wire logic [3:0]        s_axi_wstrb,   // byte lanes
   input wire logic              s_axi_wvalid,  // wr data vld
   input wire logic              s_axi_wready,  // wr data rdy
   input wire logic              s_axi_bvalid,  // wr resp vld
   input wire logic [7:0]        s_axi_araddr,  // rd addr
   input wire logic              s_axi_arvalid, // rd addr vld
   input wire logic              s_axi_arready, // rd addr rdy
   input wire logic [31:0]       s_axi_rdata,   // rd data
   input wire logic              s_axi_rvalid   // rd data vld
);
   import cmpsr_pkg::*;
   logic [7:0] rd_addr_q;
   logic       stop_q;
   logic [2:0] age_q;
   // ---------------------------------------------------------------
   // shadows: read address, stop-in-idle, age of cell inputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_addr_q <= 8'h00;
         stop_q    <= 1'h0;
         age_q     <= 3'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
         if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == OFS_STATUS && s_axi_wstrb[1])
            stop_q <= s_axi_wdata[15];
         if ($changed(i_cmp_out) || $changed(i_cmp_event)) age_q <= 3'h0;
         else if (age_q != 3'h7) age_q <= age_q + 3'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read not answered");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken during read data");
   a_status_zero: assert property (
      s_axi_rvalid && rd_addr_q == OFS_STATUS |-> s_axi_rdata[31:16] == '0
      && s_axi_rdata[14:11] == '0 && s_axi_rdata[7:3] == '0)
      else $error("status reserved bits set");
   a_ctrl_zero: assert property (
      s_axi_rvalid && rd_addr_q <= OFS_CTRL3 |-> s_axi_rdata[31:10] == '0
      && s_axi_rdata[7:5] == '0 && s_axi_rdata[3:2] == '0)
      else $error("control reserved bits set");
   a_status_mirror: assert property (
      s_axi_rvalid && rd_addr_q == OFS_STATUS && age_q == 3'h7
      |-> s_axi_rdata[10:8] == i_cmp_event && s_axi_rdata[2:0] == i_cmp_out)
      else $error("status mirror wrong");
   a_idle_mask: assert property (
      (stop_q && i_idle)[*3] |-> !o_irq) else $error("irq while idle");
   a_sel_change: assert property (
      o_inv_sel != $past(o_inv_sel) || o_noninv_sel != $past(o_noninv_sel)
      |-> $rose(s_axi_bvalid)) else $error("select moved without write");
   c_irq_rise: cover property ($rose(o_irq));
   c_idle_gate: cover property (stop_q && i_idle ##1 !o_irq);
   c_stat_read: cover property (s_axi_rvalid && rd_addr_q == OFS_STATUS);
endmodule
bind cmpsr_regs cmpsr_regs_monitor #(.NCMP(NCMP)) u_monitor (
   .i_clk, .i_rst_b, .i_idle, .i_cmp_event, .i_cmp_out, .o_noninv_sel,
   .o_inv_sel, .o_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid
);
`default_nettype wire

//--- tb/cmpsr_cells.sv
// behavioural model of the three comparator cells and input muxes
`timescale 1ns/100ps
`default_nettype none
module cmpsr_cells #(
   parameter logic [7:0] REF_LVL = 8'h80, // internal reference level
   parameter logic [7:0] HBG_LVL = 8'h30  // half bandgap level
) (
   input  wire logic       i_clk,        // clock
   input  wire logic [2:0] i_noninv_sel, // 1: internal reference
   input  wire logic [5:0] i_inv_sel,    // inverting mux per cell
   input  wire logic [7:0] i_pin [4],    // shared pins a, b, c, d
   input  wire logic       i_evt_clr,    // clears event flags
   output var  logic [2:0] o_out,        // comparison results
   output var  logic [2:0] o_event       // sticky output rise flags
);
   logic [2:0] out_q = 3'h0;
   logic [7:0] vm;
   initial o_event = 3'h0;
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         vm = (i_inv_sel[2*k+:2] == 2'h3) ? HBG_LVL
            : i_pin[i_inv_sel[2*k+:2] + 1];
         o_out[k] = (i_noninv_sel[k] ? REF_LVL : i_pin[0]) > vm;
      end
   end
   always @(posedge i_clk) begin
      out_q   <= o_out;
      o_event <= (o_event | (o_out & ~out_q)) & ~{3{i_evt_clr}};
   end
endmodule
`default_nettype wire

//--- tb/test_comparator_select_and_status_regs.sv
// self-checking bench for the comparator select and status registers
`timescale 1ns/100ps
`default_nettype none
module test_comparator_select_and_status_regs;
   import cmpsr_pkg::*;
   localparam logic [7:0] REF_LVL = 8'h80;
   localparam logic [7:0] HBG_LVL = 8'h30;
   logic        i_clk = 1'h0, i_rst_b = 1'h0, i_idle = 1'h0, evt_clr = 1'h0;
   logic [7:0]  pin [4] = '{8'h20, 8'hC0, 8'h10, 8'h70};
   logic [2:0]  i_cmp_event, i_cmp_out, o_noninv_sel;
   logic [5:0]  o_inv_sel;
   logic        o_irq;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  ns_e = 3'h0, oe = 3'h0;
   logic [5:0]  is_e = 6'h0;
   int          err_total = 0, num_checks = 0, cyc = 0;
   cmpsr_regs #(.NCMP(NUM_CMP)) DUT (
      .i_clk, .i_rst_b, .i_idle, .i_cmp_event, .i_cmp_out, .o_noninv_sel,
      .o_inv_sel, .o_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   cmpsr_cells #(.REF_LVL(REF_LVL), .HBG_LVL(HBG_LVL)) u_cells (
      .i_clk, .i_noninv_sel(o_noninv_sel), .i_inv_sel(o_inv_sel), .i_pin(pin),
      .i_evt_clr(evt_clr), .o_out(i_cmp_out), .o_event(i_cmp_event)
   );
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge i_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      forever begin
         @(posedge i_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
      @(posedge i_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      forever begin
         @(posedge i_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask
   task automatic clr_events();
      repeat (6) @(posedge i_clk);
      evt_clr <= 1'h1;
      @(posedge i_clk);
      evt_clr <= 1'h0;
      repeat (6) @(posedge i_clk);
   endtask
   function automatic logic eo(input logic n, input logic [1:0] c);
      logic [7:0] vm;
      vm = (c == INV_HALF_BGAP) ? HBG_LVL : pin[c + 1];
      return (n ? REF_LVL : pin[0]) > vm;
   endfunction
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk({o_noninv_sel, o_inv_sel, o_irq}, 32'h0);
      for (int i = 0; i < 7; i++)
         rdc(8'(i * 4), 32'h0, RESP_OKAY);
      rdc(8'h1C, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'hFFFF, RESP_SLVERR);
      $display("test reset done");
   endtask
   task automatic t_select();
      logic [2:0]  c;
      logic [31:0] d;
      for (int k = 0; k < 3; k++) begin
         for (int v = 0; v < 8; v++) begin
            c = 3'(v);
            d = 32'hFFFFFFEC | {27'h0, c[2], 2'h0, c[1:0]};
            wr(8'(4 * k), d, RESP_OKAY);
            ns_e[k] = c[2];
            is_e[2*k+:2] = c[1:0];
            oe[k] = eo(c[2], c[1:0]);
            chk({o_noninv_sel,o_inv_sel}, {ns_e,is_e});
            clr_events();
            rdc(8'(4 * k), {22'h0, 1'h0, oe[k], 3'h0, c[2], 2'h0, c[1:0]},
                RESP_OKAY);
            rdc(OFS_STATUS, {29'h0, oe}, RESP_OKAY);
         end
      end
      wr(OFS_STATUS, 32'hFFFF7FFF, RESP_OKAY);
      rdc(OFS_STATUS, {29'h0, oe}, RESP_OKAY);
      $display("test select done");
   endtask
   task automatic t_irq();
      for (int k = 0; k < 3; k++) wr(8'(4 * k), 32'h2, RESP_OKAY);
      clr_events();
      wr(OFS_INT_CLR, 32'h7, RESP_OKAY);
      wr(OFS_INT_EN, 32'h1, RESP_OKAY);
      rdc(OFS_INT_STAT, 32'h0, RESP_OKAY);
      pin[0] <= 8'h90;
      repeat (8) @(posedge i_clk);
      rdc(OFS_STATUS, 32'h0707, RESP_OKAY);
      rdc(OFS_INT_STAT, 32'h7, RESP_OKAY);
      chk(o_irq, 1'h1);
      i_idle <= 1'h1;
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'h1);
      wr(OFS_STATUS, 32'hFFFF, RESP_OKAY);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'h0);
      rdc(OFS_STATUS, 32'h8707, RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      wr(OFS_STATUS, 32'h0, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rdc(OFS_STATUS, 32'h8707, RESP_OKAY);
      i_idle <= 1'h0;
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'h1);
      wr(OFS_INT_CLR, 32'h1, RESP_OKAY);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'h0);
      rdc(OFS_INT_STAT, 32'h6, RESP_OKAY);
      wr(OFS_INT_EN, 32'h4, RESP_OKAY);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'h1);
      $display("test irq done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_b <= 1'h1;
      t_reset();
      t_select();
      t_irq();
      summarize();
   end
endmodule
`default_nettype wire
